// ==== hdl/tmr3_pkg.sv ====
package tmr3_pkg;
  // register addresses
  localparam logic [7:0] A_T01_CTRL = 8'h88;
  localparam logic [7:0] A_T01_MODE = 8'h89;
  localparam logic [7:0] A_T0_LO = 8'h8A;
  localparam logic [7:0] A_T1_LO = 8'h8B;
  localparam logic [7:0] A_T0_HI = 8'h8C;
  localparam logic [7:0] A_T1_HI = 8'h8D;
  localparam logic [7:0] A_T2_CTRL = 8'hC8;
  localparam logic [7:0] A_T2_MODE = 8'hC9;
  localparam logic [7:0] A_T2_RC_LO = 8'hCA;
  localparam logic [7:0] A_T2_RC_HI = 8'hCB;
  localparam logic [7:0] A_T2_LO = 8'hCC;
  localparam logic [7:0] A_T2_HI = 8'hCD;
  localparam logic [7:0] A_IRQ_STAT = 8'hCE;
  localparam logic [7:0] A_IRQ_MASK = 8'hCF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  // timer 0/1 control byte
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  // mode byte: timer 0 in low nibble, timer 1 in high nibble
  localparam int TM_T1_BASE = 4;
  localparam int TM_GATE = 3;
  localparam int TM_CT = 2;
  // timer 2 control and mode
  localparam int T2_TF = 7;
  localparam int T2_EXF = 6;
  localparam int T2_RCLK = 5;
  localparam int T2_TRANSMIT_BAUD_SOURCE_SELECT = 4;
  localparam int T2_EXEN = 3;
  localparam int T2_TR = 2;
  localparam int T2_CT = 1;
  localparam int T2_CP = 0;
  localparam int T2M_DOWN_COUNT_ENABLE = 0;
  // interrupt status/mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_TF0 = 0;
  localparam int IRQ_TF1 = 1;
  localparam int IRQ_TF2 = 2;
  localparam int IRQ_THIRD_TIMER_EXT_TRIGGER_FLAG = 3;
  // timing
  localparam int OSC_PER_MC = 12;
  localparam int PRESC_DIV = 32;
  localparam int BRG_DIV = 2;
  typedef enum logic [1:0] {
    MODE_PRESC, MODE_16, MODE_RELOAD, MODE_SPLIT
  } tmr3_mode_t;
endpackage

// ==== hdl/tmr3_top.sv ====
`timescale 1ns/1ns
module tmr3_top
  import tmr3_pkg::*;
#(
  parameter int MC_DIV = OSC_PER_MC
) (
  input wire logic clk, // oscillator clock
  input wire logic srst, // synchronous reset, high
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [7:0] rdata_q, // read data, cycle after strobe
  output logic irq_q, // unmasked status pending
  output logic t1_ovf_q, // timer 1 overflow pulse
  output logic t2_baud_q, // timer 2 baud overflow pulse
  input wire logic first_timer_count_pin, // timer 0 events
  input wire logic second_timer_count_pin, // timer 1 events
  input wire logic third_timer_count_pin, // timer 2 events
  input wire logic third_timer_trigger_pin, // timer 2 trigger
  input wire logic first_gate_pin, // timer 0 gate
  input wire logic second_gate_pin // timer 1 gate
);

  ////////////////////////////////////////////////////////////////////
  logic [3:0] mc_cnt_q;
  logic mc_tick_q;
  logic half_q;
  logic [7:0] timer01_control_q, timer01_mode_q, tl0_q, th0_q, tl1_q, th1_q;
  logic [7:0] timer2_control_q, timer2_reload_capture_low_q, timer2_reload_capture_high_q, tl2_q, th2_q;
  logic timer2_mode_q;
  logic [IRQ_W-1:0] stat_q, mask_q;
  logic [3:0] pin_in, s1_q, s2_q, fall;

  always_ff @(posedge clk) begin
    if (srst || mc_cnt_q == 4'(MC_DIV - 1)) begin
      mc_cnt_q <= 4'h0;
    end else begin
      mc_cnt_q <= 4'(mc_cnt_q + 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    mc_tick_q <= !srst && mc_cnt_q == 4'(MC_DIV - 1);
  end

  // divide-by-two enable for the baud generator path
  always_ff @(posedge clk) begin
    if (srst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= 1'(half_q + 1'b1 == 1'(BRG_DIV - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pins sampled once per machine cycle; an edge needs two samples,
  // which limits external rates to a twenty-fourth of the clock
  assign pin_in = {third_timer_trigger_pin, third_timer_count_pin,
                   second_timer_count_pin, first_timer_count_pin};

  for (genvar i = 0; i < 4; i++) begin : g_edge
    always_ff @(posedge clk) begin
      if (srst) begin
        s1_q[i] <= 1'b1;
        s2_q[i] <= 1'b1;
      end else if (mc_tick_q) begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
      end
    end
    assign fall[i] = mc_tick_q & s2_q[i] & ~s1_q[i];
  end

  ////////////////////////////////////////////////////////////////////
  tmr3_mode_t md0, md1;
  logic first_timer_run_bit, second_timer_run_bit;
  logic gate0, gate1, ct0, ct1, t0_inc, t1_inc, th0_inc;
  logic ov0, ov1, ovh0, tf1_evt;
  logic [7:0] tl0_d, th0_d, tl1_d, th1_d;

  assign md0 = tmr3_mode_t'(timer01_mode_q[1:0]);
  assign md1 = tmr3_mode_t'(timer01_mode_q[TM_T1_BASE+1:TM_T1_BASE]);
  assign first_timer_run_bit = timer01_control_q[TC_TR0];
  assign second_timer_run_bit = timer01_control_q[TC_TR1];
  assign gate0 = timer01_mode_q[TM_GATE];
  assign gate1 = timer01_mode_q[TM_T1_BASE+TM_GATE];
  assign ct0 = timer01_mode_q[TM_CT];
  assign ct1 = timer01_mode_q[TM_T1_BASE+TM_CT];
  assign t0_inc = first_timer_run_bit & (~gate0 | first_gate_pin) &
                  (ct0 ? fall[0] : mc_tick_q);
  assign t1_inc = second_timer_run_bit & (~gate1 | second_gate_pin) &
                  (ct1 ? fall[1] : mc_tick_q) &
                  (md1 != MODE_SPLIT);
  // split mode: high byte of timer 0 borrows timer 1's run bit
  assign th0_inc = (md0 == MODE_SPLIT) & second_timer_run_bit &
                   mc_tick_q;

  function automatic logic [16:0] step(input tmr3_mode_t m,
      input logic inc, input logic [7:0] tl, input logic [7:0] th);
    logic [16:0] r;
    r = {1'b0, th, tl};
    if (inc) begin
      case (m)
        MODE_PRESC: begin
          r[$clog2(PRESC_DIV)-1:0] = 5'(tl[4:0] + 5'h01);
          if (tl[4:0] == 5'h1F) begin
            r[15:8] = 8'(th + 8'h01);
            r[16] = (th == 8'hFF);
          end
        end
        MODE_16: begin
          r[15:0] = 16'({th, tl} + 16'h0001);
          r[16] = ({th, tl} == 16'hFFFF);
        end
        MODE_RELOAD: begin
          r[7:0] = (tl == 8'hFF) ? th : 8'(tl + 8'h01);
          r[16] = (tl == 8'hFF);
        end
        MODE_SPLIT: begin
          r[7:0] = 8'(tl + 8'h01);
          r[16] = (tl == 8'hFF);
        end
        default: begin
          r = {1'b0, th, tl};
        end
      endcase
    end
    return r;
  endfunction

  always_comb begin
    {ov0, th0_d, tl0_d} = step(md0, t0_inc, tl0_q, th0_q);
    {ov1, th1_d, tl1_d} = step(md1, t1_inc, tl1_q, th1_q);
    ovh0 = 1'b0;
    if (th0_inc) begin
      th0_d = 8'(th0_q + 8'h01);
      ovh0 = (th0_q == 8'hFF);
    end
  end

  assign tf1_evt = (md0 == MODE_SPLIT) ? ovh0 : ov1;

  ////////////////////////////////////////////////////////////////////
  logic baud, down_count_enable, third_timer_run_bit, third_timer_ext_enable;
  logic t2_tick, ex_fall, ex_act, tf2_evt, bovf;
  logic [15:0] cnt2, rc2, cnt2_d, rc2_d;

  assign cnt2 = {th2_q, tl2_q};
  assign rc2 = {timer2_reload_capture_high_q, timer2_reload_capture_low_q};
  assign baud = timer2_control_q[T2_RCLK] | timer2_control_q[T2_TRANSMIT_BAUD_SOURCE_SELECT];
  assign down_count_enable = timer2_mode_q;
  assign third_timer_run_bit = timer2_control_q[T2_TR];
  assign third_timer_ext_enable = timer2_control_q[T2_EXEN];
  assign t2_tick = third_timer_run_bit & (timer2_control_q[T2_CT] ? fall[2] :
                   (baud ? half_q : mc_tick_q));
  assign ex_fall = third_timer_ext_enable & fall[3];
  assign ex_act = ex_fall & third_timer_run_bit;

  always_comb begin
    cnt2_d = cnt2;
    rc2_d = rc2;
    tf2_evt = 1'b0;
    bovf = 1'b0;
    if (baud) begin
      // overflow feeds the serial clock only, never the flag
      if (t2_tick) begin
        cnt2_d = (cnt2 == 16'hFFFF) ? rc2 : 16'(cnt2 + 16'h0001);
        bovf = (cnt2 == 16'hFFFF);
      end
    end else if (timer2_control_q[T2_CP]) begin
      if (t2_tick) begin
        cnt2_d = 16'(cnt2 + 16'h0001);
        tf2_evt = (cnt2 == 16'hFFFF);
      end
      if (ex_act) begin
        rc2_d = cnt2;
      end
    end else if (down_count_enable) begin
      if (t2_tick && third_timer_trigger_pin) begin
        cnt2_d = (cnt2 == 16'hFFFF) ? rc2 : 16'(cnt2 + 16'h0001);
        tf2_evt = (cnt2 == 16'hFFFF);
      end else if (t2_tick) begin
        cnt2_d = (cnt2 == rc2) ? 16'hFFFF : 16'(cnt2 - 16'h0001);
        tf2_evt = (cnt2 == rc2);
      end
    end else begin
      if (ex_act || (t2_tick && cnt2 == 16'hFFFF)) begin
        cnt2_d = rc2;
      end else if (t2_tick) begin
        cnt2_d = 16'(cnt2 + 16'h0001);
      end
      tf2_evt = t2_tick && cnt2 == 16'hFFFF;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      timer01_control_q <= RST_BYTE;
      timer2_control_q <= RST_BYTE;
    end else begin
      timer01_control_q <= (wr_en && addr == A_T01_CTRL ? wdata : timer01_control_q) |
                (8'(tf1_evt) << TC_TF1) |
                (8'(ov0) << TC_TF0);
      timer2_control_q <= (wr_en && addr == A_T2_CTRL ? wdata : timer2_control_q) |
                 (8'(tf2_evt) << T2_TF) |
                 (8'(ex_fall) << T2_EXF);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timer01_mode_q <= RST_BYTE;
      timer2_mode_q <= 1'b0;
    end else if (wr_en && addr == A_T01_MODE) begin
      timer01_mode_q <= wdata;
    end else if (wr_en && addr == A_T2_MODE) begin
      timer2_mode_q <= wdata[T2M_DOWN_COUNT_ENABLE];
    end
  end

  // a software write to a count byte overrides that cycle's count
  always_ff @(posedge clk) begin
    if (srst) begin
      tl0_q <= RST_BYTE;
      th0_q <= RST_BYTE;
      tl1_q <= RST_BYTE;
      th1_q <= RST_BYTE;
    end else begin
      tl0_q <= (wr_en && addr == A_T0_LO) ? wdata : tl0_d;
      th0_q <= (wr_en && addr == A_T0_HI) ? wdata : th0_d;
      tl1_q <= (wr_en && addr == A_T1_LO) ? wdata : tl1_d;
      th1_q <= (wr_en && addr == A_T1_HI) ? wdata : th1_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tl2_q <= RST_BYTE;
      th2_q <= RST_BYTE;
      timer2_reload_capture_low_q <= RST_BYTE;
      timer2_reload_capture_high_q <= RST_BYTE;
    end else begin
      tl2_q <= (wr_en && addr == A_T2_LO) ? wdata : cnt2_d[7:0];
      th2_q <= (wr_en && addr == A_T2_HI) ? wdata : cnt2_d[15:8];
      timer2_reload_capture_low_q <= (wr_en && addr == A_T2_RC_LO) ? wdata : rc2_d[7:0];
      timer2_reload_capture_high_q <= (wr_en && addr == A_T2_RC_HI) ? wdata : rc2_d[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  logic [IRQ_W-1:0] evts, w1c;

  assign evts = {ex_fall, tf2_evt, tf1_evt, ov0};
  assign w1c = (wr_en && addr == A_IRQ_STAT) ? wdata[IRQ_W-1:0] :
               {IRQ_W{1'b0}};

  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= {IRQ_W{1'b0}};
      mask_q <= {IRQ_W{1'b0}};
      irq_q <= 1'b0;
      t1_ovf_q <= 1'b0;
      t2_baud_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~w1c) | evts;
      if (wr_en && addr == A_IRQ_MASK) begin
        mask_q <= wdata[IRQ_W-1:0];
      end
      irq_q <= |(stat_q & mask_q);
      t1_ovf_q <= ov1;
      t2_baud_q <= bovf;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !rd_en) begin
      rdata_q <= RD_NONE;
    end else begin
      case (addr)
        A_T01_CTRL: rdata_q <= timer01_control_q;
        A_T01_MODE: rdata_q <= timer01_mode_q;
        A_T0_LO: rdata_q <= tl0_q;
        A_T1_LO: rdata_q <= tl1_q;
        A_T0_HI: rdata_q <= th0_q;
        A_T1_HI: rdata_q <= th1_q;
        A_T2_CTRL: rdata_q <= timer2_control_q;
        A_T2_MODE: rdata_q <= 8'(timer2_mode_q);
        A_T2_RC_LO: rdata_q <= timer2_reload_capture_low_q;
        A_T2_RC_HI: rdata_q <= timer2_reload_capture_high_q;
        A_T2_LO: rdata_q <= tl2_q;
        A_T2_HI: rdata_q <= th2_q;
        A_IRQ_STAT: rdata_q <= 8'(stat_q);
        A_IRQ_MASK: rdata_q <= 8'(mask_q);
        default: rdata_q <= RD_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  mc_period_a: assert property (@(posedge clk) disable iff (srst)
    mc_tick_q |=> (!mc_tick_q [*8] ##1 !mc_tick_q ##1 !mc_tick_q
                   ##1 !mc_tick_q ##1 mc_tick_q))
    else $error("machine cycle tick period wrong");

  presc_carry_a: assert property (@(posedge clk) disable iff (srst)
    (md0 == MODE_PRESC && t0_inc && tl0_q[4:0] == 5'h1F && !wr_en)
    |=> th0_q == 8'($past(th0_q) + 8'h01) && tl0_q[4:0] == 5'h00)
    else $error("prescaler carry not taken");

  full16_carry_a: assert property (@(posedge clk) disable iff (srst)
    (md0 == MODE_16 && t0_inc && tl0_q == 8'hFF && !wr_en)
    |=> th0_q == 8'($past(th0_q) + 8'h01) && tl0_q == 8'h00)
    else $error("16-bit carry lost");

  auto_reload_a: assert property (@(posedge clk) disable iff (srst)
    (md0 == MODE_RELOAD && t0_inc && tl0_q == 8'hFF && !wr_en)
    |=> tl0_q == $past(th0_q) && timer01_control_q[TC_TF0])
    else $error("8-bit reload missed");

  t1_stopped_a: assert property (@(posedge clk) disable iff (srst)
    (md1 == MODE_SPLIT && !wr_en) |=> $stable({th1_q, tl1_q}))
    else $error("timer 1 moved in split mode");

  edge_count_a: assert property (@(posedge clk) disable iff (srst)
    (md0 == MODE_16 && ct0 && first_timer_run_bit && !gate0 &&
     fall[0] && tl0_q != 8'hFF && !wr_en)
    |=> tl0_q == 8'($past(tl0_q) + 8'h01))
    else $error("falling edge not counted");

  gate_hold_a: assert property (@(posedge clk) disable iff (srst)
    (gate0 && !first_gate_pin && md0 == MODE_16 && !wr_en)
    |=> $stable({th0_q, tl0_q}))
    else $error("timer 0 counted while gated off");

  down_count_a: assert property (@(posedge clk) disable iff (srst)
    (!baud && !timer2_control_q[T2_CP] && down_count_enable && t2_tick &&
     !third_timer_trigger_pin && cnt2 != rc2 && !wr_en)
    |=> cnt2 == 16'($past(cnt2) - 16'h0001))
    else $error("timer 2 did not count down");

  capture_a: assert property (@(posedge clk) disable iff (srst)
    (!baud && timer2_control_q[T2_CP] && ex_act && !wr_en) |=> rc2 == $past(cnt2))
    else $error("capture value wrong");

  baud_noflag_a: assert property (@(posedge clk) disable iff (srst)
    (baud && !timer2_control_q[T2_TF] && !wr_en) |=> !timer2_control_q[T2_TF])
    else $error("overflow flag set in baud mode");

  t2_stop_a: assert property (@(posedge clk) disable iff (srst)
    (!third_timer_run_bit && !wr_en) |=> $stable(cnt2))
    else $error("timer 2 counted while stopped");

  trig_flag_a: assert property (@(posedge clk) disable iff (srst)
    ex_fall |=> timer2_control_q[T2_EXF] && stat_q[IRQ_THIRD_TIMER_EXT_TRIGGER_FLAG]
      ##1 (irq_q || !$past(mask_q[IRQ_THIRD_TIMER_EXT_TRIGGER_FLAG])))
    else $error("trigger flag not set");

endmodule // tmr3_top

// ==== tb/tmr3_pins.sv ====
`timescale 1ns/1ns
module tmr3_pins #(
  parameter int MC_DIV = 12
) (
  input wire logic clk, // oscillator clock
  output logic [2:0] cnt, // count pins, timers 0..2
  output logic trig, // timer 2 trigger pin
  output logic [1:0] gate // gate pins, timers 0/1
);
  // idle high, so a fresh sampler sees no false edge
  initial begin
    cnt = 3'h7;
    trig = 1'b1;
    gate = 2'h3;
  end
  //////////////////////////////////////////////////////////////////////////
  // each level held three machine cycles: the sampler needs two
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge clk);
      if (which == 3)
        trig <= 1'b0;
      else
        cnt[which] <= 1'b0;
      repeat (3 * MC_DIV) @(posedge clk);
      if (which == 3)
        trig <= 1'b1;
      else
        cnt[which] <= 1'b1;
      repeat (3 * MC_DIV) @(posedge clk);
    end
  endtask
endmodule // tmr3_pins

// ==== tb/timer_counters_0_1_2_bench.sv ====
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module timer_counters_0_1_2_bench
  import tmr3_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata_q;
  logic irq_q;
  logic t1_ovf_q;
  logic t2_baud_q;
  logic [2:0] cnt;
  logic trig;
  logic [1:0] gate;
  logic [7:0] d;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] regs [15] = '{A_T01_CTRL, A_T01_MODE, A_T0_LO, A_T1_LO,
    A_T0_HI, A_T1_HI, A_T2_CTRL, A_T2_MODE, A_T2_RC_LO, A_T2_RC_HI,
    A_T2_LO, A_T2_HI, A_IRQ_STAT, A_IRQ_MASK, 8'h8E};
  logic [7:0] c_md [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
  logic [7:0] c_tl [4] = '{8'hFF, 8'hFD, 8'h1F, 8'h00};
  logic [7:0] c_th [4] = '{8'hFF, 8'hFD, 8'hFF, 8'hFF};
  logic [7:0] c_ct [4] = '{8'h10, 8'h10, 8'h10, 8'h40};
  logic [7:0] c_ex [4] = '{8'h00, 8'hFD, 8'h00, 8'h00};
  int c_fb [4] = '{TC_TF0, TC_TF0, TC_TF0, TC_TF1};
  logic [7:0] u_md [3] = '{8'h00, 8'h01, 8'h01};
  logic u_tr [3] = '{1'b1, 1'b0, 1'b0};
  logic [7:0] u_ct [3] = '{8'h04, 8'h04, 8'h05};
  logic [15:0] u_st [3] = '{16'hFFFF, 16'h0001, 16'hFFFF};
  logic [15:0] u_rc [3] = '{16'hABCD, 16'h0000, 16'h1234};
  logic [15:0] u_ex [3] = '{16'hABCD, 16'hFFFF, 16'h0000};

  always #5 clk = ~clk;

  tmr3_pins #(.MC_DIV(OSC_PER_MC)) pins (
    .clk(clk),
    .cnt(cnt),
    .trig(trig),
    .gate(gate)
  );

  tmr3_top #(.MC_DIV(OSC_PER_MC)) dut (
    .clk(clk),
    .srst(srst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata_q(rdata_q),
    .irq_q(irq_q),
    .t1_ovf_q(t1_ovf_q),
    .t2_baud_q(t2_baud_q),
    .first_timer_count_pin(cnt[0]),
    .second_timer_count_pin(cnt[1]),
    .third_timer_count_pin(cnt[2]),
    .third_timer_trigger_pin(trig),
    .first_gate_pin(gate[0]),
    .second_gate_pin(gate[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata_q;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(d, e)
  endtask

  task automatic wait_bit(input logic [7:0] a, input int b);
    d = 8'h00;
    for (int i = 0; i < 300 && d[b] !== 1'b1; i++)
      rd(a);
    if (d[b] !== 1'b1) begin
      `CHK(d[b], 1'b1)
      report_and_stop();
    end
  endtask

  // irq follows status one cycle late
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq_q, e)
  endtask

  task automatic run0(input int n);
    wr(A_T01_CTRL, 8'h10);
    repeat (n) @(posedge clk);
    wr(A_T01_CTRL, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (regs[i])
      rchk(regs[i], RST_BYTE);
    wr(A_T01_MODE, 8'hA5);
    rchk(A_T01_MODE, 8'hA5);
    wr(A_T2_MODE, 8'hFF);
    rchk(A_T2_MODE, 8'h01);
    wr(8'h8E, 8'h5A);
    rchk(8'h8E, RD_NONE);
    $display("end registers");
    for (int i = 0; i < 4; i++) begin
      wr(A_T0_LO, c_tl[i]);
      wr(A_T0_HI, c_th[i]);
      wr(A_T01_MODE, c_md[i]);
      wr(A_T01_CTRL, c_ct[i]);
      wait_bit(A_T01_CTRL, c_fb[i]);
      wr(A_T01_CTRL, 8'h00);
      rchk(A_T0_LO, c_ex[i]);
      rchk(A_T0_HI, c_ex[i]);
    end
    $display("end timer 0 modes");
    rchk(A_IRQ_STAT, 8'h03);
    wr(A_IRQ_MASK, 8'h02);
    irq_chk(1'b1);
    wr(A_IRQ_MASK, 8'h01);
    wr(A_IRQ_STAT, 8'h01);
    irq_chk(1'b0);
    rchk(A_IRQ_STAT, 8'h02);
    wr(A_IRQ_MASK, 8'h00);
    $display("end interrupts");
    wr(A_T0_LO, 8'h00);
    wr(A_T0_HI, 8'h00);
    wr(A_T01_MODE, 8'h09);
    @(posedge clk) pins.gate[0] <= 1'b0;
    run0(240);
    rchk(A_T0_LO, 8'h00);
    @(posedge clk) pins.gate[0] <= 1'b1;
    run0(240);
    rd(A_T0_LO);
    `CHK(d >= 8'h13 && d <= 8'h15, 1'b1)
    wr(A_T0_LO, 8'h00);
    wr(A_T01_MODE, 8'h05);
    wr(A_T01_CTRL, 8'h10);
    pins.pulse(0, 3);
    wr(A_T01_CTRL, 8'h00);
    pins.pulse(0, 1);
    rchk(A_T0_LO, 8'h03);
    wr(A_T1_LO, 8'h55);
    wr(A_T01_MODE, 8'h30);
    wr(A_T01_CTRL, 8'h40);
    repeat (60) @(posedge clk);
    wr(A_T01_CTRL, 8'h00);
    rchk(A_T1_LO, 8'h55);
    wr(A_T1_LO, 8'hFF);
    wr(A_T1_HI, 8'hFF);
    wr(A_T01_MODE, 8'h10);
    wr(A_T01_CTRL, 8'h40);
    for (int i = 0; i < 40 && t1_ovf_q !== 1'b1; i++)
      @(posedge clk) #1;
    `CHK(t1_ovf_q, 1'b1)
    rchk(A_T01_CTRL, 8'hC0);
    wr(A_T01_CTRL, 8'h00);
    $display("end gate, rate and events");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) pins.trig <= u_tr[i];
      wr(A_T2_MODE, u_md[i]);
      wr(A_T2_RC_LO, u_rc[i][7:0]);
      wr(A_T2_RC_HI, u_rc[i][15:8]);
      wr(A_T2_LO, u_st[i][7:0]);
      wr(A_T2_HI, u_st[i][15:8]);
      wr(A_T2_CTRL, u_ct[i]);
      wait_bit(A_T2_CTRL, T2_TF);
      wr(A_T2_CTRL, 8'h00);
      rchk(A_T2_LO, u_ex[i][7:0]);
      rchk(A_T2_HI, u_ex[i][15:8]);
    end
    @(posedge clk) pins.trig <= 1'b1;
    wr(A_T2_MODE, 8'h00);
    wr(A_T2_LO, 8'h34);
    wr(A_T2_HI, 8'h12);
    wr(A_T2_CTRL, 8'h0F);
    pins.pulse(3, 1);
    rchk(A_T2_CTRL, 8'h4F);
    rchk(A_T2_RC_LO, 8'h34);
    rchk(A_T2_RC_HI, 8'h12);
    wr(A_T2_LO, 8'h00);
    wr(A_T2_HI, 8'h00);
    wr(A_T2_CTRL, 8'h0E);
    pins.pulse(3, 1);
    rchk(A_T2_LO, 8'h34);
    rchk(A_T2_HI, 8'h12);
    pins.pulse(2, 2);
    rchk(A_T2_LO, 8'h36);
    rchk(A_T2_HI, 8'h12);
    wr(A_T2_LO, 8'hFF);
    wr(A_T2_HI, 8'hFF);
    wr(A_T2_CTRL, 8'h24);
    for (int i = 0; i < 40 && t2_baud_q !== 1'b1; i++)
      @(posedge clk) #1;
    `CHK(t2_baud_q, 1'b1)
    rchk(A_T2_CTRL, 8'h24);
    wr(A_T2_CTRL, 8'h00);
    $display("end timer 2");
    report_and_stop();
  end
endmodule // timer_counters_0_1_2_bench
